// file: core/cccc_consts.svh
// Command codes, field positions and reset values for the channel config block
`ifndef CCCC_CONSTS_SVH
`define CCCC_CONSTS_SVH

`define CCCC_CMD_DEACT    8'h00
`define CCCC_CMD_SOFT_RST 8'h02
`define CCCC_CMD_ACT      8'h0E
`define CCCC_CMD_WR_SLOT  8'h44
`define CCCC_CMD_RD_SLOT  8'h45
`define CCCC_CMD_WR_DELAY 8'h50
`define CCCC_CMD_RD_DELAY 8'h51
`define CCCC_CMD_WR_IOOUT 8'h52
`define CCCC_CMD_RD_PINS  8'h53
`define CCCC_CMD_WR_IODIR 8'h54
`define CCCC_CMD_RD_STAT  8'h55
`define CCCC_CMD_WR_OPFN  8'h60
`define CCCC_CMD_RD_OPFN  8'h61

`define CCCC_BIT_EDGE     6
`define CCCC_BIT_DELAY    7
`define CCCC_BIT_TXGAIN   6
`define CCCC_BIT_RXLOSS   5
`define CCCC_BIT_ADAPT    7
`define CCCC_BIT_BFILT    0

`define CCCC_SCALE_CUTOFF 5'h00
`define CCCC_SCALE_LOOP   5'h10
`define CCCC_SCALE_RST    5'h00
`define CCCC_OPFN_RST     8'h00
`define CCCC_OE_N_RST     5'h1F
`define CCCC_SYNC_W       11

`endif

// file: core/cccc_pkg.sv
// Types for the channel config block
package cccc_pkg;

  typedef enum logic {CCCC_IDLE, CCCC_DATA} cccc_fsm_t;

  typedef struct packed {
    cccc_fsm_t fsm;
    logic [7:0] cmd;
    logic chan;
    logic tx_edge;
    logic [1:0][2:0] tx_slot;
    logic [1:0][2:0] rx_slot;
    logic [1:0] dly_rm;
    logic [1:0] tx_gain;
    logic [1:0] rx_loss;
    logic [1:0][4:0] scale;
    logic [1:0] scale_loop;
    logic [1:0] scale_cut;
    logic [1:0][4:0] io_latch;
    logic [1:0][4:0] io_oe_n;
    logic [1:0] pwr_flag;
    logic [1:0] active;
    logic [1:0][7:0] opfn;
    logic [1:0] adapt_act;
    logic rd_valid;
    logic [7:0] rd_byte;
  } cccc_state_t;

endpackage

// file: core/cccc_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module cccc_sync #(
  parameter int W = 11
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // cccc_sync

// file: core/cccc_top.sv
// Command interpreter holding per-channel codec configuration and status
`timescale 1ns/100ps
`include "cccc_consts.svh"
module cccc_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  input wire logic in_chan,
  input wire logic power_fail,
  input wire logic [9:0] line_io_in,
  output logic rd_valid,
  output logic [7:0] rd_byte,
  output logic [9:0] line_io_out,
  output logic [9:0] line_io_oe_n,
  output logic tx_edge_select,
  output logic [5:0] tx_clock_slot,
  output logic [5:0] rx_clock_slot,
  output logic [1:0] pcm_delay_remove,
  output logic [1:0] tx_gain_step,
  output logic [1:0] rx_loss_step,
  output logic [9:0] impedance_scaling_gain,
  output logic [1:0] scaling_loopback,
  output logic [1:0] scaling_cutoff,
  output logic [1:0] adaptive_balance_select,
  output logic [1:0] mu_law_select,
  output logic [1:0] rx_gain_filter_en,
  output logic [1:0] tx_gain_filter_en,
  output logic [1:0] x_filter_en,
  output logic [1:0] r_filter_en,
  output logic [1:0] z_filter_en,
  output logic [1:0] balance_filter_en,
  output logic [1:0] adaptive_balance_active,
  output logic [1:0] channel_active_flag,
  output logic [1:0] power_loss_flag
);
  import cccc_pkg::*;

  cccc_pkg::cccc_state_t cur;
  cccc_pkg::cccc_state_t next_cur;
  logic [`CCCC_SYNC_W-1:0] sync_q;
  logic [1:0][4:0] pins_s;
  logic pwr_s;

  //////////////////////////////////////////////////////////////////////////
  // Pin inputs

  cccc_sync #(.W(`CCCC_SYNC_W)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({power_fail, line_io_in}),
    .q(sync_q)
  );

  assign pins_s = sync_q[9:0];
  assign pwr_s = sync_q[10];

  //////////////////////////////////////////////////////////////////////////
  // Read answer assembly; reserved bits return 0

  function automatic logic [7:0] rd_mux(
    input logic [7:0] code,
    input logic ch,
    input cccc_state_t s,
    input logic [1:0][4:0] pins
  );
    logic [7:0] r;
    r = 8'h00;
    case (code)
      `CCCC_CMD_RD_SLOT:
        r = {1'b0, s.tx_edge, s.rx_slot[ch], s.tx_slot[ch]};
      `CCCC_CMD_RD_DELAY:
        r = {s.dly_rm[ch], s.tx_gain[ch], s.rx_loss[ch],
             s.scale[ch]};
      `CCCC_CMD_RD_PINS:
        r = {3'b000, pins[ch]};
      `CCCC_CMD_RD_STAT:
        r = {s.pwr_flag[ch], s.active[ch], 1'b0, ~s.io_oe_n[ch]};
      `CCCC_CMD_RD_OPFN:
        r = s.opfn[ch];
      default:
        r = 8'h00;
    endcase
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Command decode

  always_comb
  begin
    next_cur = cur;
    next_cur.rd_valid = 1'b0;
    if (in_valid)
    begin
      case (cur.fsm)
        CCCC_IDLE:
        begin
          next_cur.cmd = in_byte;
          next_cur.chan = in_chan;
          case (in_byte)
            `CCCC_CMD_WR_SLOT, `CCCC_CMD_WR_DELAY, `CCCC_CMD_WR_IOOUT,
            `CCCC_CMD_WR_IODIR, `CCCC_CMD_WR_OPFN:
              next_cur.fsm = CCCC_DATA;
            `CCCC_CMD_RD_SLOT, `CCCC_CMD_RD_DELAY, `CCCC_CMD_RD_PINS,
            `CCCC_CMD_RD_STAT, `CCCC_CMD_RD_OPFN:
            begin
              next_cur.rd_valid = 1'b1;
              next_cur.rd_byte = rd_mux(in_byte, in_chan, cur, pins_s);
            end
            `CCCC_CMD_DEACT:
              next_cur.active[in_chan] = 1'b0;
            `CCCC_CMD_ACT:
              next_cur.active[in_chan] = 1'b1;
            `CCCC_CMD_SOFT_RST:
            begin
              // Slots, delay and output latch survive a software reset
              next_cur.active[in_chan] = 1'b0;
              next_cur.tx_gain[in_chan] = 1'b0;
              next_cur.rx_loss[in_chan] = 1'b0;
              next_cur.scale[in_chan] = `CCCC_SCALE_RST;
              next_cur.opfn[in_chan] = `CCCC_OPFN_RST;
              next_cur.io_oe_n[in_chan] = `CCCC_OE_N_RST;
              next_cur.pwr_flag[in_chan] = 1'b0;
            end
            default:
              next_cur.fsm = CCCC_IDLE;
          endcase
        end
        CCCC_DATA:
        begin
          next_cur.fsm = CCCC_IDLE;
          case (cur.cmd)
            `CCCC_CMD_WR_SLOT:
            begin
              // Bit 7 is reserved and not stored
              next_cur.tx_edge = in_byte[`CCCC_BIT_EDGE];
              next_cur.rx_slot[cur.chan] = in_byte[5:3];
              next_cur.tx_slot[cur.chan] = in_byte[2:0];
            end
            `CCCC_CMD_WR_DELAY:
            begin
              next_cur.dly_rm[cur.chan] =
                in_byte[`CCCC_BIT_DELAY];
              next_cur.tx_gain[cur.chan] = in_byte[`CCCC_BIT_TXGAIN];
              next_cur.rx_loss[cur.chan] = in_byte[`CCCC_BIT_RXLOSS];
              next_cur.scale[cur.chan] = in_byte[4:0];
            end
            `CCCC_CMD_WR_IOOUT:
              next_cur.io_latch[cur.chan] = in_byte[4:0];
            `CCCC_CMD_WR_IODIR:
              next_cur.io_oe_n[cur.chan] = ~in_byte[4:0];
            `CCCC_CMD_WR_OPFN:
              next_cur.opfn[cur.chan] = in_byte;
            default:
              next_cur.fsm = CCCC_IDLE;
          endcase
        end
        default:
          next_cur.fsm = CCCC_IDLE;
      endcase
    end
    // Power loss set wins over a same-cycle software reset clear
    if (pwr_s)
      next_cur.pwr_flag = 2'b11;
    for (int c = 0; c < 2; c++)
    begin
      next_cur.adapt_act[c] = next_cur.opfn[c][`CCCC_BIT_ADAPT]
        & next_cur.opfn[c][`CCCC_BIT_BFILT];
      next_cur.scale_loop[c] = next_cur.scale[c] == `CCCC_SCALE_LOOP;
      next_cur.scale_cut[c] = next_cur.scale[c] == `CCCC_SCALE_CUTOFF;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur <= '0;
      cur.io_oe_n <= {`CCCC_OE_N_RST, `CCCC_OE_N_RST};
      cur.scale_cut <= 2'b11;
    end
    else
      cur <= next_cur;
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign rd_valid = cur.rd_valid;
  assign rd_byte = cur.rd_byte;
  assign line_io_out = cur.io_latch;
  assign line_io_oe_n = cur.io_oe_n;
  assign tx_edge_select = cur.tx_edge;
  assign tx_clock_slot = cur.tx_slot;
  assign rx_clock_slot = cur.rx_slot;
  assign pcm_delay_remove = cur.dly_rm;
  assign tx_gain_step = cur.tx_gain;
  assign rx_loss_step = cur.rx_loss;
  assign impedance_scaling_gain = cur.scale;
  assign scaling_loopback = cur.scale_loop;
  assign scaling_cutoff = cur.scale_cut;
  assign adaptive_balance_select = {cur.opfn[1][7], cur.opfn[0][7]};
  assign mu_law_select = {cur.opfn[1][6], cur.opfn[0][6]};
  assign rx_gain_filter_en = {cur.opfn[1][5], cur.opfn[0][5]};
  assign tx_gain_filter_en = {cur.opfn[1][4], cur.opfn[0][4]};
  assign x_filter_en = {cur.opfn[1][3], cur.opfn[0][3]};
  assign r_filter_en = {cur.opfn[1][2], cur.opfn[0][2]};
  assign z_filter_en = {cur.opfn[1][1], cur.opfn[0][1]};
  assign balance_filter_en = {cur.opfn[1][0], cur.opfn[0][0]};
  assign adaptive_balance_active = cur.adapt_act;
  assign channel_active_flag = cur.active;
  assign power_loss_flag = cur.pwr_flag;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_cmd(logic [7:0] code);
    cur.fsm == CCCC_IDLE && in_valid && in_byte == code;
  endsequence

  sequence s_data(logic [7:0] code);
    cur.fsm == CCCC_DATA && in_valid && cur.cmd == code;
  endsequence

  edge_shared_a: assert property (
    s_data(`CCCC_CMD_WR_SLOT) |=> tx_edge_select == $past(in_byte[6]))
    else $error("edge bit not taken from write");

  slot_write_a: assert property (
    s_data(`CCCC_CMD_WR_SLOT) |=>
      cur.tx_slot[$past(cur.chan)] == $past(in_byte[2:0]) &&
      cur.rx_slot[$past(cur.chan)] == $past(in_byte[5:3]))
    else $error("clock slot write lost");

  slot_read_a: assert property (
    s_cmd(`CCCC_CMD_RD_SLOT) |=> rd_valid && rd_byte[7] == 1'b0 &&
      rd_byte[6] == tx_edge_select)
    else $error("slot read answer wrong");

  delay_write_a: assert property (
    s_data(`CCCC_CMD_WR_DELAY) |=>
      pcm_delay_remove[$past(cur.chan)] == $past(in_byte[7]) &&
      cur.scale[$past(cur.chan)] == $past(in_byte[4:0]))
    else $error("delay and scaling write lost");

  loop_decode_a: assert property (
    s_data(`CCCC_CMD_WR_DELAY) ##1 1'b1 |->
      scaling_loopback[cur.chan] == (cur.scale[cur.chan] == `CCCC_SCALE_LOOP))
    else $error("loopback decode wrong");

  latch_write_a: assert property (
    s_data(`CCCC_CMD_WR_IOOUT) |=>
      cur.io_latch[$past(cur.chan)] == $past(in_byte[4:0]))
    else $error("pin latch write lost");

  pin_read_a: assert property (
    s_cmd(`CCCC_CMD_RD_PINS) |=>
      rd_valid && rd_byte == {3'b000, $past(pins_s[in_chan])})
    else $error("pin readback wrong");

  power_set_a: assert property (
    pwr_s |=> power_loss_flag == 2'b11)
    else $error("power flag not set");

  reset_io_a: assert property (
    s_cmd(`CCCC_CMD_SOFT_RST) |=>
      cur.io_oe_n[$past(in_chan)] == 5'h1F &&
      !channel_active_flag[$past(in_chan)])
    else $error("soft reset left pins driven");

  active_set_a: assert property (
    s_cmd(`CCCC_CMD_ACT) |=> channel_active_flag[$past(in_chan)] ##1
      (channel_active_flag[cur.chan] || $past(in_valid)))
    else $error("activate not shown");

  adapt_gate_a: assert property (
    adaptive_balance_active ==
      (adaptive_balance_select & balance_filter_en))
    else $error("adaptive active without balance filter");

  delay_read_a: assert property (
    s_cmd(`CCCC_CMD_RD_DELAY) |=> rd_valid &&
      rd_byte[4:0] == cur.scale[$past(in_chan)] &&
      rd_byte[7] == pcm_delay_remove[$past(in_chan)])
    else $error("delay read answer wrong");

  dir_write_a: assert property (
    s_data(`CCCC_CMD_WR_IODIR) |=>
      cur.io_oe_n[$past(cur.chan)] == ~$past(in_byte[4:0]))
    else $error("pin direction write lost");

  stat_read_a: assert property (
    s_cmd(`CCCC_CMD_RD_STAT) |=> rd_valid && rd_byte[5] == 1'b0 &&
      rd_byte[4:0] == ~cur.io_oe_n[$past(in_chan)] &&
      rd_byte[6] == channel_active_flag[$past(in_chan)])
    else $error("status read answer wrong");

  opfn_write_a: assert property (
    s_data(`CCCC_CMD_WR_OPFN) |=>
      cur.opfn[$past(cur.chan)] == $past(in_byte))
    else $error("operating functions write lost");

  deactivate_shown_a: assert property (
    s_cmd(`CCCC_CMD_DEACT) |=> !channel_active_flag[$past(in_chan)])
    else $error("deactivate not shown");

  power_clear_a: assert property (
    s_cmd(`CCCC_CMD_SOFT_RST) ##0 !pwr_s |=>
      !power_loss_flag[$past(in_chan)])
    else $error("power flag not cleared by soft reset");

endmodule // cccc_top

// file: tb/cccc_host.sv
// Host model feeding command and data bytes into the port
`timescale 1ns/100ps
module cccc_host (
  input wire logic clk,
  input wire logic rd_valid,
  input wire logic [7:0] rd_byte,
  output logic in_valid,
  output logic [7:0] in_byte,
  output logic in_chan
);
  logic [1:0] dly = 2'b00;
  logic edge_on = 1'b0;
  initial
  begin
    in_valid = 1'b0;
    in_byte = 8'h00;
    in_chan = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic put(input logic [7:0] b, input logic c);
    @(negedge clk);
    in_valid = 1'b1;
    in_byte = b;
    in_chan = c;
  endtask
  // Released byte lines flip so stale data never looks valid
  task automatic idle;
    @(negedge clk);
    in_valid = 1'b0;
    in_byte = ~in_byte;
  endtask
  task automatic send(input logic [7:0] b, input logic c);
    put(b, c);
    idle;
  endtask
  task automatic wr(input logic [7:0] k, inout logic [7:0] d, input logic c);
    if (k == 8'h44)
      d[7] = 1'b0;
    if (k == 8'h52 || k == 8'h54)
      d[7:5] = 3'b000;
    if (k == 8'h44 && dly != 2'b11)
      d[6] = 1'b0;
    if (k == 8'h50 && edge_on)
      d[7] = 1'b1;
    if (k == 8'h44)
      edge_on = d[6];
    if (k == 8'h50)
      dly[c] = d[7];
    put(k, c);
    put(d, c);
    idle;
  endtask
  task automatic rd(input logic [7:0] k, input logic c, output logic v,
                    output logic [7:0] b);
    put(k, c);
    idle;
    v = rd_valid;
    b = rd_byte;
  endtask
endmodule // cccc_host

// file: tb/tb.sv
// Self-checking bench for the channel config command block
`timescale 1ns/100ps
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, a); end end
module tb;
  logic clk, reset_n, power_fail, in_valid, in_chan, rd_valid, tx_edge_select;
  logic [7:0] in_byte, rd_byte;
  logic [9:0] line_io_in, line_io_out, line_io_oe_n, scale_o, ext;
  logic [5:0] tx_clock_slot, rx_clock_slot;
  logic [1:0] dly_o, txg_o, rxl_o, lp_o, cut_o, adsel_o, mu_o, rxgf_o, txgf_o;
  logic [1:0] xf_o, rf_o, zf_o, bf_o, adact_o, act_o, pw_o, pw, act;
  logic [2:0] ts[2], rs[2];
  logic [7:0] dg[2], op[2];
  logic [4:0] dir[2], lat[2];
  logic edge_b;
  logic [31:0] x = 32'h0000_0002;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  // Pin level: our driver where enabled, else the line card side
  assign line_io_in = (~line_io_oe_n & line_io_out) | (line_io_oe_n & ext);
  cccc_host i_host (.clk(clk), .rd_valid(rd_valid), .rd_byte(rd_byte),
    .in_valid(in_valid), .in_byte(in_byte), .in_chan(in_chan));
  cccc_top i_dut (.clk(clk), .reset_n(reset_n), .in_valid(in_valid),
    .in_byte(in_byte), .in_chan(in_chan), .power_fail(power_fail),
    .line_io_in(line_io_in), .rd_valid(rd_valid), .rd_byte(rd_byte),
    .line_io_out(line_io_out), .line_io_oe_n(line_io_oe_n),
    .tx_edge_select(tx_edge_select), .tx_clock_slot(tx_clock_slot),
    .rx_clock_slot(rx_clock_slot), .pcm_delay_remove(dly_o),
    .tx_gain_step(txg_o), .rx_loss_step(rxl_o),
    .impedance_scaling_gain(scale_o),
    .scaling_loopback(lp_o), .scaling_cutoff(cut_o),
    .adaptive_balance_select(adsel_o), .mu_law_select(mu_o),
    .rx_gain_filter_en(rxgf_o), .tx_gain_filter_en(txgf_o),
    .x_filter_en(xf_o), .r_filter_en(rf_o), .z_filter_en(zf_o),
    .balance_filter_en(bf_o),
    .adaptive_balance_active(adact_o), .channel_active_flag(act_o),
    .power_loss_flag(pw_o));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [4:0] f_pins(input int c);
    return (dir[c] & lat[c]) | (~dir[c] & ext[c*5+:5]);
  endfunction
  function automatic logic [7:0] f_rd(input logic [7:0] k, input int c);
    case (k)
      8'h45: return {1'b0, edge_b, rs[c], ts[c]};
      8'h51: return dg[c];
      8'h53: return {3'b000, f_pins(c)};
      8'h55: return {pw[c], act[c], 1'b0, dir[c]};
      default: return op[c];
    endcase
  endfunction
  task automatic upd(input logic [7:0] k, input logic [7:0] d, input int c);
    case (k)
      8'h44: {edge_b, rs[c], ts[c]} = d[6:0];
      8'h50: dg[c] = d;
      8'h52: lat[c] = d[4:0];
      8'h54: dir[c] = d[4:0];
      default: op[c] = d;
    endcase
  endtask
  task automatic chk_all;
    for (int c = 0; c < 2; c++)
    begin
      logic [7:0] o;
      o = {adsel_o[c], mu_o[c], rxgf_o[c], txgf_o[c], xf_o[c], rf_o[c],
           zf_o[c], bf_o[c]};
      `CHK("tx_slot", ts[c], tx_clock_slot[c*3+:3])
      `CHK("rx_slot", rs[c], rx_clock_slot[c*3+:3])
      `CHK("dly_gain", dg[c][7:5], {dly_o[c], txg_o[c], rxl_o[c]})
      `CHK("scale", dg[c][4:0], scale_o[c*5+:5])
      `CHK("scale_mode", {dg[c][4:0] == 5'h10, dg[c][4:0] == 5'h00},
           {lp_o[c], cut_o[c]})
      `CHK("opfn", op[c], o)
      `CHK("adapt_act", op[c][7] & op[c][0], adact_o[c])
      `CHK("io_oe_n", ~dir[c], line_io_oe_n[c*5+:5])
      `CHK("io_out", lat[c], line_io_out[c*5+:5])
      `CHK("flags", {pw[c], act[c]}, {pw_o[c], act_o[c]})
    end
    `CHK("edge", edge_b, tx_edge_select)
  endtask
  task automatic rd_all(input logic c);
    logic [7:0] b, m, k;
    logic v;
    for (int i = 0; i < 5; i++)
    begin
      k = (i == 0) ? 8'h45 : (i == 1) ? 8'h51 : (i == 2) ? 8'h53 : 8'h61;
      k = (i == 3) ? 8'h55 : k;
      // Reserved read bits are undefined, so they are masked out
      m = (k == 8'h45) ? 8'h7F : (k == 8'h55) ? 8'hDF : 8'hFF;
      m = (k == 8'h53) ? 8'h1F : m;
      i_host.rd(k, c, v, b);
      `CHK("rd_valid", 1'b1, v)
      `CHK("rd_byte", f_rd(k, c) & m, b & m)
    end
  endtask
  task automatic step;
    logic [31:0] r;
    logic [7:0] d, k;
    logic c;
    int s;
    r = rnd();
    c = r[0];
    d = r[8:1];
    ext = r[18:9];
    s = int'(r[23:19]) % 9;
    if (r[26:24] == 3'h0)
      power_fail = ~power_fail;
    repeat (4) @(negedge clk);
    pw = pw | {2{power_fail}};
    k = (s == 0) ? 8'h44 : (s == 1) ? 8'h50 : (s == 2) ? 8'h52 : 8'h60;
    k = (s == 3) ? 8'h54 : k;
    if (s < 5)
    begin
      i_host.wr(k, d, c);
      upd(k, d, c);
    end
    else if (s < 8)
    begin
      k = (s == 5) ? 8'h00 : (s == 6) ? 8'h0E : 8'h02;
      i_host.send(k, c);
      act[c] = (s == 6);
      if (s == 7)
      begin
        op[c] = 8'h00;
        dg[c] = dg[c] & 8'h80;
        dir[c] = 5'h00;
        pw[c] = power_fail;
      end
    end
    repeat (3) @(negedge clk);
    chk_all;
    rd_all(c);
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done;
    end
  end
  initial
  begin
    logic [7:0] d;
    reset_n = 1'b0;
    power_fail = 1'b0;
    ext = 10'h000;
    pw = 2'b00;
    act = 2'b00;
    edge_b = 1'b0;
    for (int c = 0; c < 2; c++)
      {ts[c], rs[c], dg[c], op[c], dir[c], lat[c]} = '0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    chk_all;
    rd_all(1'b0);
    rd_all(1'b1);
    d = 8'h10;
    i_host.wr(8'h50, d, 1'b1);
    upd(8'h50, d, 1);
    chk_all;
    d = 8'h9F;
    i_host.wr(8'h50, d, 1'b0);
    upd(8'h50, d, 0);
    i_host.send(8'h06, 1'b0);
    chk_all;
    for (int i = 0; i < 80; i++)
      step;
    // Idle line pins end up as outputs to save power
    for (int c = 0; c < 2; c++)
    begin
      d = 8'h1F;
      i_host.wr(8'h54, d, c[0]);
      upd(8'h54, d, c);
    end
    chk_all;
    rd_all(1'b0);
    test_done;
  end
endmodule // tb
